/* src/quick_request_pkg.sv */
// package: register map, option field layout and state types for quick engine
package quick_request_pkg;

    // register byte offsets (normal set and submitting pseudo set)
    localparam logic [7:0] OFF_OPTIONS = 8'h00;
    localparam logic [7:0] OFF_SOURCE = 8'h04;
    localparam logic [7:0] OFF_COUNT = 8'h08;
    localparam logic [7:0] OFF_DEST = 8'h0C;
    localparam logic [7:0] OFF_INDEX = 8'h10;
    localparam logic [7:0] OFF_PSEUDO_BASE = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h40;
    localparam logic [7:0] OFF_PENDING = 8'h44;
    localparam logic [7:0] OFF_VARIANT = 8'h48;

    // option field positions
    localparam int PRI_HI = 31;
    localparam int PRI_LO = 29;
    localparam int SIZE_HI = 28;
    localparam int SIZE_LO = 27;
    localparam int SRC_2D_BIT = 26;
    localparam int SRC_UPD_HI = 25;
    localparam int SRC_UPD_LO = 24;
    localparam int DST_2D_BIT = 23;
    localparam int DST_UPD_HI = 22;
    localparam int DST_UPD_LO = 21;
    localparam int DONE_IRQ_BIT = 20;
    localparam int CODE_HI = 19;
    localparam int CODE_LO = 16;
    localparam int FRAME_BIT = 0;

    // codes
    localparam logic [2:0] PRI_HIGH = 3'h1;
    localparam logic [2:0] PRI_LOW_BASE = 3'h2;
    localparam logic [2:0] PRI_LOW_EXT = 3'h3;
    localparam logic [1:0] UPD_INC = 2'h1;
    localparam logic [1:0] UPD_DEC = 2'h2;

    // reset values
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

    // one queued request, all five parameters
    typedef struct packed {
        logic [31:0] options;
        logic [31:0] source;
        logic [31:0] count;
        logic [31:0] dest;
        logic [31:0] index;
    } request_t;

    // engine memory-side request
    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [1:0] size;
        logic [31:0] wdata;
    } mem_req_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_WRITE
    } engine_state_t;

endpackage

/* src/quick_request_queue.sv */
// file: small request queue holding submitted transfer requests
`timescale 1ns/10ps
`default_nettype none
module quick_request_queue #(
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // fill side
    input wire logic push,
    input wire quick_request_pkg::request_t push_data,
    output logic full,
    // drain side
    input wire logic pop,
    output quick_request_pkg::request_t head,
    output logic not_empty
);
    localparam int AW = $clog2(DEPTH);

    // the wrap bit of the pointers only works for powers of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
        $error("queue depth must be a power of two, at least 2");

    // storage array
    quick_request_pkg::request_t mem [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;

    assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign not_empty = (wr_q != rd_q);
    assign head = mem[rd_q[AW-1:0]];

    // write pointer and store
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wr_q <= '0;
        else if (push && !full)
            wr_q <= wr_q + 1'b1;
    end

    // data store has no reset; only valid entries are ever read
    always_ff @(posedge pclk)
    begin
        if (push && !full)
            mem[wr_q[AW-1:0]] <= push_data;
    end

    // read pointer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rd_q <= '0;
        else if (pop && not_empty)
            rd_q <= rd_q + 1'b1;
    end
endmodule
`default_nettype wire

/* src/quick_address_step.sv */
// file: address update for one side of the transfer
`timescale 1ns/10ps
`default_nettype none
module quick_address_step (
    // current address and settings
    input wire logic [31:0] addr,
    input wire logic [1:0] mode,
    input wire logic two_dim,
    input wire logic [2:0] bytes,
    input wire logic [15:0] arr_index,
    input wire logic last_in_array,
    // next address
    output logic [31:0] next_addr
);
    logic [31:0] stepped;

    // element step: increment, decrement or hold
    always_comb
    begin
        stepped = addr;
        if (mode == quick_request_pkg::UPD_INC)
            stepped = addr + {29'h0, bytes};
        else if (mode == quick_request_pkg::UPD_DEC)
            stepped = addr - {29'h0, bytes};
    end

    // gap between arrays is added after the last element's step
    always_comb
    begin
        next_addr = stepped;
        if (two_dim && last_in_array)
            next_addr = stepped + {{16{arr_index[15]}}, arr_index};
    end
endmodule
`default_nettype wire

/* src/quick_request_transfer_engine.sv */
// file: top of the quick request transfer engine with its APB slave
//
// Notes on behaviour
// - frame sync 1-D moves whole block
// - element sync 1-D moves first element only
// - element count is 16 bits wide
// - pseudo address write stores and submits
// - code 001 goes to high queue
// - priority bits 31..29, ext low 011
// - update mode 01 increments per element
// - block sync 2-D moves whole subframe
// - array index added after array end
// - array count plus one arrays moved
// - requests queue while earlier ones run
// - code reported only with interrupt bit
// - only single basic submissions served here
// - chaining absent from quick set
// - reported code sets sticky pending flag
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module quick_request_transfer_engine #(
    parameter int QUEUE_DEPTH = 4
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // memory master port
    output quick_request_pkg::mem_req_t mem_req,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    // completion report
    output logic done_valid,
    output logic [3:0] done_code
);
    // refused at elaboration, so a bad depth never builds
    if (QUEUE_DEPTH < 2)
        $error("queue depth too small");

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic access;
    logic wr_en;
    logic pseudo;
    logic [7:0] reg_off;
    logic mapped;

    assign access = psel && penable && pready;
    assign wr_en = access && pwrite;
    // pseudo set mirrors the normal set one window higher
    assign pseudo = (paddr >= quick_request_pkg::OFF_PSEUDO_BASE) &&
                    (paddr < quick_request_pkg::OFF_STATUS);
    assign reg_off = pseudo ? paddr - quick_request_pkg::OFF_PSEUDO_BASE
                            : paddr;

    always_comb
    begin
        case (reg_off)
            quick_request_pkg::OFF_OPTIONS,
            quick_request_pkg::OFF_SOURCE,
            quick_request_pkg::OFF_COUNT,
            quick_request_pkg::OFF_DEST,
            quick_request_pkg::OFF_INDEX: mapped = 1'b1;
            quick_request_pkg::OFF_STATUS,
            quick_request_pkg::OFF_PENDING,
            quick_request_pkg::OFF_VARIANT: mapped = !pseudo;
            default: mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // parameter registers
    // ------------------------------------------------------------
    logic [31:0] options_q;   // quick_transfer_options
    logic [31:0] source_q;    // quick_source_address
    logic [31:0] count_q;     // quick_transfer_count
    logic [31:0] dest_q;      // quick_destination_address
    logic [31:0] index_q;     // quick_array_element_index
    logic ext_variant_q;      // variant bit, only stored and read back; queue routing ignores it
    logic [15:0] pending_q;   // pending flags
    quick_request_pkg::request_t submit_req;
    logic submit;
    logic q_full;
    logic busy_q; // engine is working on a request

    // plain writes only store; the pseudo copy also submits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            options_q <= quick_request_pkg::REG_RESET;
            source_q <= quick_request_pkg::REG_RESET;
            count_q <= quick_request_pkg::REG_RESET;
            dest_q <= quick_request_pkg::REG_RESET;
            index_q <= quick_request_pkg::REG_RESET;
        end
        else if (wr_en)
        begin
            case (reg_off)
                quick_request_pkg::OFF_OPTIONS: options_q <= pwdata;
                quick_request_pkg::OFF_SOURCE: source_q <= pwdata;
                quick_request_pkg::OFF_COUNT: count_q <= pwdata;
                quick_request_pkg::OFF_DEST: dest_q <= pwdata;
                quick_request_pkg::OFF_INDEX: index_q <= pwdata;
                default: ;
            endcase
        end
    end

    // variant select register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ext_variant_q <= 1'b0;
        else if (wr_en && !pseudo &&
                 paddr == quick_request_pkg::OFF_VARIANT)
            ext_variant_q <= pwdata[0];
    end

    // submitted request merges the written field with stored ones
    always_comb
    begin
        submit_req.options = options_q;
        submit_req.source = source_q;
        submit_req.count = count_q;
        submit_req.dest = dest_q;
        submit_req.index = index_q;
        case (reg_off)
            quick_request_pkg::OFF_OPTIONS: submit_req.options = pwdata;
            quick_request_pkg::OFF_SOURCE: submit_req.source = pwdata;
            quick_request_pkg::OFF_COUNT: submit_req.count = pwdata;
            quick_request_pkg::OFF_DEST: submit_req.dest = pwdata;
            quick_request_pkg::OFF_INDEX: submit_req.index = pwdata;
            default: ;
        endcase
    end

    assign submit = wr_en && pseudo && mapped;

    // ------------------------------------------------------------
    // priority routing into two queues
    // ------------------------------------------------------------
    logic [2:0] sub_pri;
    logic to_high;
    logic hi_full;
    logic lo_full;
    logic hi_pop;
    logic lo_pop;
    logic hi_ne;
    logic lo_ne;
    quick_request_pkg::request_t hi_head;
    quick_request_pkg::request_t lo_head;

    assign sub_pri = submit_req.options[quick_request_pkg::PRI_HI:
                                        quick_request_pkg::PRI_LO];
    assign to_high = (sub_pri == quick_request_pkg::PRI_HIGH);
    assign q_full = to_high ? hi_full : lo_full;

    // both queues let software run ahead of the engine
    quick_request_queue #(.DEPTH(QUEUE_DEPTH)) u_high_queue (
        .pclk(pclk),
        .presetn(presetn),
        .push(submit && to_high),
        .push_data(submit_req),
        .full(hi_full),
        .pop(hi_pop),
        .head(hi_head),
        .not_empty(hi_ne)
    );

    quick_request_queue #(.DEPTH(QUEUE_DEPTH)) u_low_queue (
        .pclk(pclk),
        .presetn(presetn),
        .push(submit && !to_high),
        .push_data(submit_req),
        .full(lo_full),
        .pop(lo_pop),
        .head(lo_head),
        .not_empty(lo_ne)
    );

    // ------------------------------------------------------------
    // apb answer: stall a pseudo write while its queue is full
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
        else if (psel && !penable)
        begin
            pready <= 1'b0;
        end
        else if (psel && penable && !pready)
        begin
            // one wait state, longer while the target queue is full
            pready <= !(pwrite && pseudo && mapped && q_full);
            pslverr <= !mapped;
            case (paddr)
                quick_request_pkg::OFF_OPTIONS: prdata <= options_q;
                quick_request_pkg::OFF_SOURCE: prdata <= source_q;
                quick_request_pkg::OFF_COUNT: prdata <= count_q;
                quick_request_pkg::OFF_DEST: prdata <= dest_q;
                quick_request_pkg::OFF_INDEX: prdata <= index_q;
                quick_request_pkg::OFF_STATUS:
                    prdata <= {28'h0, lo_full, hi_full, lo_ne | hi_ne,
                               busy_q};
                quick_request_pkg::OFF_PENDING: prdata <= {16'h0, pending_q};
                quick_request_pkg::OFF_VARIANT:
                    prdata <= {31'h0, ext_variant_q};
                default: prdata <= '0;
            endcase
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // transfer engine
    // ------------------------------------------------------------
    quick_request_pkg::engine_state_t state_q;
    quick_request_pkg::request_t act_q;
    logic [31:0] src_q;
    logic [31:0] dst_q;
    logic [15:0] elem_left_q;
    logic [15:0] arr_left_q;
    logic [31:0] data_q;
    logic [2:0] ebytes;
    logic last_elem;
    logic last_arr;
    logic sync_elem_only;
    logic [31:0] src_next;
    logic [31:0] dst_next;
    logic [1:0] esz;

    assign esz = act_q.options[quick_request_pkg::SIZE_HI:
                               quick_request_pkg::SIZE_LO];
    // size code 0 is a word, 1 a halfword, 2 a byte
    assign ebytes = (esz == 2'h0) ? 3'h4 : (esz == 2'h1) ? 3'h2 : 3'h1;
    assign last_elem = (elem_left_q <= 16'h0001);
    assign last_arr = (arr_left_q == 16'h0000);
    // element sync with nothing 2-D moves one element only
    assign sync_elem_only = !act_q.options[quick_request_pkg::FRAME_BIT] &&
        !act_q.options[quick_request_pkg::SRC_2D_BIT] &&
        !act_q.options[quick_request_pkg::DST_2D_BIT];

    quick_address_step u_src_step (
        .addr(src_q),
        .mode(act_q.options[quick_request_pkg::SRC_UPD_HI:
                            quick_request_pkg::SRC_UPD_LO]),
        .two_dim(act_q.options[quick_request_pkg::SRC_2D_BIT]),
        .bytes(ebytes),
        .arr_index(act_q.index[31:16]),
        .last_in_array(last_elem),
        .next_addr(src_next)
    );

    quick_address_step u_dst_step (
        .addr(dst_q),
        .mode(act_q.options[quick_request_pkg::DST_UPD_HI:
                            quick_request_pkg::DST_UPD_LO]),
        .two_dim(act_q.options[quick_request_pkg::DST_2D_BIT]),
        .bytes(ebytes),
        .arr_index(act_q.index[31:16]),
        .last_in_array(last_elem),
        .next_addr(dst_next)
    );

    // high queue always wins the next free slot
    assign hi_pop = (state_q == quick_request_pkg::ST_IDLE) && hi_ne;
    assign lo_pop = (state_q == quick_request_pkg::ST_IDLE) && !hi_ne && lo_ne;

    // sequencing: read element, write element, step, repeat
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= quick_request_pkg::ST_IDLE;
            act_q <= '0;
            busy_q <= 1'b0;
            src_q <= '0;
            dst_q <= '0;
            elem_left_q <= '0;
            arr_left_q <= '0;
            data_q <= '0;
        end
        else
        begin
            case (state_q)
                quick_request_pkg::ST_IDLE:
                begin
                    busy_q <= hi_pop | lo_pop;
                    if (hi_pop | lo_pop)
                    begin
                        act_q <= hi_pop ? hi_head : lo_head;
                        src_q <= hi_pop ? hi_head.source : lo_head.source;
                        dst_q <= hi_pop ? hi_head.dest : lo_head.dest;
                        elem_left_q <= hi_pop ? hi_head.count[15:0]
                                              : lo_head.count[15:0];
                        arr_left_q <= hi_pop ? hi_head.count[31:16]
                                             : lo_head.count[31:16];
                        state_q <= quick_request_pkg::ST_READ;
                    end
                end
                quick_request_pkg::ST_READ:
                begin
                    if (mem_ack)
                    begin
                        data_q <= mem_rdata;
                        state_q <= quick_request_pkg::ST_WRITE;
                    end
                end
                quick_request_pkg::ST_WRITE:
                begin
                    if (mem_ack)
                    begin
                        src_q <= src_next;
                        dst_q <= dst_next;
                        if (sync_elem_only || (last_elem && last_arr))
                        begin
                            // one element, or every array, is done
                            state_q <= quick_request_pkg::ST_IDLE;
                            busy_q <= 1'b0;
                        end
                        else if (last_elem)
                        begin
                            // next array of the subframe
                            elem_left_q <= act_q.count[15:0];
                            arr_left_q <= arr_left_q - 16'h0001;
                            state_q <= quick_request_pkg::ST_READ;
                        end
                        else
                        begin
                            elem_left_q <= elem_left_q - 16'h0001;
                            state_q <= quick_request_pkg::ST_READ;
                        end
                    end
                end
                default: state_q <= quick_request_pkg::ST_IDLE;
            endcase
        end
    end

    // memory request registered from the state it belongs to
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mem_req <= '0;
        else
        begin
            mem_req.valid <= !mem_ack &&
                ((state_q == quick_request_pkg::ST_READ) ||
                 (state_q == quick_request_pkg::ST_WRITE));
            mem_req.write <= (state_q == quick_request_pkg::ST_WRITE);
            mem_req.addr <= (state_q == quick_request_pkg::ST_WRITE) ? dst_q
                                                                     : src_q;
            mem_req.size <= esz;
            mem_req.wdata <= data_q;
        end
    end

    // ------------------------------------------------------------
    // completion report and pending flags
    // ------------------------------------------------------------
    logic finish;
    logic report;
    logic [3:0] code;

    assign finish = (state_q == quick_request_pkg::ST_WRITE) && mem_ack &&
                    (sync_elem_only || (last_elem && last_arr));
    assign report = finish && act_q.options[quick_request_pkg::DONE_IRQ_BIT];
    assign code = act_q.options[quick_request_pkg::CODE_HI:
                                quick_request_pkg::CODE_LO];

    // completion pulse only when the interrupt bit was set
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            done_valid <= 1'b0;
            done_code <= '0;
        end
        else
        begin
            done_valid <= report;
            done_code <= report ? code : done_code;
        end
    end

    // write one clears; a new report in the same cycle wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pending_q <= '0;
        else
        begin
            pending_q <= (pending_q & ~((wr_en && !pseudo &&
                          paddr == quick_request_pkg::OFF_PENDING)
                          ? pwdata[15:0] : 16'h0)) |
                         (report ? (16'h0001 << code) : 16'h0);
        end
    end
endmodule
`default_nettype wire

/* tb/quick_request_transfer_engine_checker.sv */
// checker: port assertions for the quick request transfer engine
`timescale 1ns/10ps
`default_nettype none
module quick_request_transfer_engine_checker (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb answer side
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // memory port and completion
    input wire quick_request_pkg::mem_req_t mem_req,
    input wire logic mem_ack,
    input wire logic done_valid,
    input wire logic [3:0] done_code
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // the setup cycle is never answered: one wait state
    property p_setup; psel && !penable |=> !pready; endproperty
    a_setup: assert property (p_setup) else $error("early pready");
    property p_phase; pready |-> psel && penable; endproperty
    a_phase: assert property (p_phase) else $error("stray pready");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("long pready");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("lone pslverr");
    // completion report is a single pulse, its code holds between reports
    property p_done; done_valid |=> !done_valid; endproperty
    a_done: assert property (p_done) else $error("long done");
    property p_code; !done_valid |-> $stable(done_code); endproperty
    a_code: assert property (p_code) else $error("code moved");
    // a memory request holds until acknowledged, then drops
    property p_hold; mem_req.valid && !mem_ack |=> $stable(mem_req);
    endproperty
    a_hold: assert property (p_hold) else $error("req moved");
    property p_rw;
        mem_req.valid && mem_ack && !mem_req.write |=>
            !mem_req.valid ##[1:8] mem_req.valid && mem_req.write;
    endproperty
    a_rw: assert property (p_rw) else $error("no write after read");
endmodule
bind quick_request_transfer_engine quick_request_transfer_engine_checker
    chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .mem_req,
    .mem_ack, .done_valid, .done_code);
`default_nettype wire

/* tb/quick_mem_model.sv */
// model: word memory answering the engine's requests
`timescale 1ns/10ps
`default_nettype none
module quick_mem_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // request side
    input wire quick_request_pkg::mem_req_t mem_req,
    input wire logic slow,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [0:255];
    int wait_q;
    // idle read data toggles so a late sample never looks right
    always @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            mem_ack <= 1'b0;
            mem_rdata <= 32'h0;
            wait_q <= 0;
        end
        else if (mem_ack || !mem_req.valid || wait_q < (slow ? 3 : 0))
        begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_q <= (mem_req.valid && !mem_ack) ? wait_q + 1 : 0;
        end
        else
        begin
            mem_ack <= 1'b1;
            wait_q <= 0;
            if (mem_req.write)
                mem[mem_req.addr[9:2]] <= mem_req.wdata;
            else
                mem_rdata <= mem[mem_req.addr[9:2]];
        end
endmodule
`default_nettype wire

/* tb/quick_request_transfer_engine_test.sv */
// testbench: apb scenarios for the quick request transfer engine
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    failures++; $display("ERROR %s exp %h got %h", n, e, g); end end
module quick_request_transfer_engine_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic slow = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, mem_rdata, rd_q;
    logic pready, pslverr, mem_ack, done_valid, err_q;
    logic [3:0] done_code;
    quick_request_pkg::mem_req_t mem_req;
    int failures = 0;
    int total_checks = 0;
    int i;
    initial forever #12.5 pclk = ~pclk;
    quick_request_transfer_engine dut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mem_req,
        .mem_ack, .mem_rdata, .done_valid, .done_code);
    quick_mem_model mem_i (.pclk, .presetn, .mem_req, .slow, .mem_ack,
        .mem_rdata);
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // one transfer, held until pready is sampled high
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d = 0);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n++ < 100)
            @(posedge pclk);
        `CHK("apb wait", 1'b1, pready)
        if (n > 100)
            final_report();
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(logic [7:0] a, logic [31:0] e);
        apb(1'b0, a);
        `CHK("reg", e, rd_q)
    endtask
    // bounded wait for a completion pulse, then its code
    task automatic wdone(logic [3:0] c);
        for (i = 0; i < 2000 && done_valid !== 1'b1; i++)
            @(posedge pclk);
        `CHK("done_code", c, done_code)
        if (i == 2000)
            final_report();
    endtask
    task automatic idle();
        for (i = 0; i < 200; i++)
        begin
            apb(1'b0, 8'h40);
            if (rd_q[3:0] === 4'h0)
                break;
        end
        `CHK("idle", 4'h0, rd_q[3:0])
    endtask
    // options word built field by field
    function automatic logic [31:0] opt(logic [2:0] p, logic s2, logic fr,
        logic ti, logic [3:0] c);
        return {p, 2'h0, s2, 2'h1, 1'b0, 2'h1, ti, c, 15'h0, fr};
    endfunction
    function automatic logic [31:0] pat(int w);
        return 32'h5A00_0000 + w;
    endfunction
    initial
    begin
        for (i = 0; i < 256; i++)
            mem_i.mem[i] = pat(i);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int r = 0; r < 5; r++)
            rchk(8'(r * 4), quick_request_pkg::REG_RESET);
        rchk(8'h3C, 32'h0);
        `CHK("slverr", 1'b1, err_q)
        // plain writes only store; the pseudo options write submits
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h08, 32'h4);
        apb(1'b1, 8'h0C, 32'h200);
        rchk(8'h0C, 32'h200);
        `CHK("no move", pat(128), mem_i.mem[128])
        apb(1'b1, 8'h20, opt(3'h1, 1'b0, 1'b1, 1'b1, 4'h5));
        wdone(4'h5);
        for (int k = 0; k < 5; k++)
            `CHK("block", pat(k < 4 ? k : 132), mem_i.mem[128 + k])
        rchk(8'h44, 32'h20);
        apb(1'b1, 8'h44, 32'h20);
        rchk(8'h44, 32'h0);
        apb(1'b1, 8'h48, 32'h1);
        rchk(8'h48, 32'h1);
        // element sync moves the first element only, no report
        apb(1'b1, 8'h0C, 32'h280);
        apb(1'b1, 8'h20, opt(3'h1, 1'b0, 1'b0, 1'b0, 4'h0));
        idle();
        `CHK("first", pat(0), mem_i.mem[160])
        `CHK("second", pat(161), mem_i.mem[161])
        rchk(8'h44, 32'h0);
        // 2-D source: three arrays of two words, eight-byte gap
        apb(1'b1, 8'h04, 32'h40);
        apb(1'b1, 8'h08, {16'h2, 16'h2});
        apb(1'b1, 8'h0C, 32'h300);
        apb(1'b1, 8'h00, opt(3'h2, 1'b1, 1'b1, 1'b1, 4'h9));
        apb(1'b1, 8'h30, {16'h8, 16'h0});
        wdone(4'h9);
        for (int k = 0; k < 6; k++)
            `CHK("2d", pat(16 + k + k / 2 * 2), mem_i.mem[192 + k])
        // slow memory: a second request queues behind the first
        slow <= 1'b1;
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h08, 32'h3);
        apb(1'b1, 8'h0C, 32'h380);
        apb(1'b1, 8'h10, 32'h8);
        apb(1'b1, 8'h20, opt(3'h3, 1'b0, 1'b1, 1'b0, 4'h0));
        apb(1'b1, 8'h00, opt(3'h1, 1'b0, 1'b1, 1'b1, 4'h3));
        apb(1'b1, 8'h04, 32'hC);
        apb(1'b1, 8'h2C, 32'h3C0);
        wdone(4'h3);
        idle();
        for (int k = 0; k < 3; k++)
        begin
            `CHK("queued lo", pat(k), mem_i.mem[224 + k])
            `CHK("queued hi", pat(3 + k), mem_i.mem[240 + k])
        end
        final_report();
    end
endmodule
`default_nettype wire
